// [rtl/utic_defs.svh]
`ifndef UTIC_DEFS_SVH
`define UTIC_DEFS_SVH
`define UTIC_MCLK_HZ 100000000
`define UTIC_AW 8
`define UTIC_CMD_OFS 8'h00
`define UTIC_CFG_OFS 8'h04
`define UTIC_ONT_OFS 8'h08
`define UTIC_OFFT_OFS 8'h0C
`define UTIC_STAT_OFS 8'h10
`define UTIC_CMD_ONOFF 0
`define UTIC_CMD_ION 1
`define UTIC_CMD_TDEC5 2
`define UTIC_CMD_BTN 3
`define UTIC_CFG_MODE_LSB 0
`define UTIC_CFG_TGL 2
`define UTIC_CFG_RST 3'h0
`define UTIC_TMR_W 11
`define UTIC_SEC_PER_MIN 60
`define UTIC_LEAD_MIN 60
`define UTIC_SAMPLE_S 30
`define UTIC_RS_MIN_S (2 * 60 + 58)
`define UTIC_RS_MAX_S (3 * 60 + 52)
`define UTIC_RS_PATTERNS 10
`define UTIC_RS_STEP_S ((`UTIC_RS_MAX_S - `UTIC_RS_MIN_S) / (`UTIC_RS_PATTERNS - 1))
`define UTIC_LFSR_RST 8'h5A
`define UTIC_ODFAN_HOLD_S 30
`define UTIC_ION_ON_S 10
`define UTIC_ION_REST_MIN 30
`define UTIC_ION_CYCLES 24
`define UTIC_BRK_S 2
`define UTIC_W1_S 5
`define UTIC_W2_S 8
`define UTIC_W3_S 11
`define UTIC_W4_S 16
`define UTIC_W5_S 21
`define UTIC_BRK_BEEPS 4
`define UTIC_BEEP_EN_RST 1'h1
`define UTIC_SENS_EN_RST 1'h1
`define UTIC_RESP_OKAY 2'h0
`define UTIC_RESP_SLVERR 2'h2
`endif

// [rtl/utic_pkg.sv]
package utic_pkg;
   typedef enum logic [1:0] {
      UNIT_OFF = 2'h0,
      UNIT_RUN = 2'h1,
      UNIT_ION = 2'h2,
      UNIT_HSTBY = 2'h3
   } utic_unit_t;
   typedef enum logic [1:0] {
      MODE_AUTO = 2'h0,
      MODE_COOL = 2'h1,
      MODE_DRY = 2'h2,
      MODE_HEAT = 2'h3
   } utic_mode_t;
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } utic_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } utic_axi_rsp_t;
   typedef struct packed {
      logic sampling;
      logic [1:0] mode;
      logic [1:0] code_sel;
      logic comp;
      logic offt_act;
      logic ont_act;
      logic sensor_detect_en;
      logic beep_en;
      logic code_arm;
      logic heat_stby;
      logic ionizer_breakdown_code;
      logic lockout;
      logic ion_on;
      logic ion_only;
      logic run;
   } utic_stat_t;
   typedef struct packed {
      logic indoor_fan;
      logic lowest_fan_step;
      logic outdoor_fan;
      logic comp;
      logic ionizer;
      logic vane_cool_law;
      logic led_power;
      logic led_timer;
      logic led_ion;
      logic buzzer;
      logic ionizer_breakdown_code;
      logic sensor_detect_en;
      logic [1:0] mode;
      logic [1:0] code_sel;
   } utic_plant_t;
endpackage

// [rtl/utic_ctrl.sv]
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "utic_defs.svh"
module utic_ctrl #(
   parameter int unsigned HALF_CYCLES = `UTIC_MCLK_HZ / 2
) (
   input wire logic mclk,
   input wire logic rst,
   input wire utic_pkg::utic_axi_req_t axi_req,
   output var utic_pkg::utic_axi_rsp_t axi_rsp,
   input wire logic auto_sw,
   input wire logic ion_fb,
   input wire logic was_running,
   input wire logic timer_was_set,
   input wire logic hot_start,
   input wire logic deicing,
   input wire logic mode_judge,
   input wire logic abnormal,
   output var utic_pkg::utic_plant_t plant
);
   localparam logic [16:0] LEAD_S = 17'(`UTIC_LEAD_MIN * `UTIC_SEC_PER_MIN);
   localparam logic [10:0] REST_S = 11'(`UTIC_ION_REST_MIN * `UTIC_SEC_PER_MIN);
   localparam logic [10:0] ON_S = 11'(`UTIC_ION_ON_S);

   // Half-second and one-second enables.
   logic [26:0] div_ff;
   logic half_ff;
   logic sec_ff;
   logic hsel_ff;
   wire div_end = (div_ff == 27'(HALF_CYCLES - 1));
   wire [26:0] nxt_div = div_end ? 27'h0 : div_ff + 27'h1;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_ff <= 27'h0;
         half_ff <= 1'h0;
         sec_ff <= 1'h0;
         hsel_ff <= 1'h0;
      end else begin
         div_ff <= nxt_div;
         half_ff <= div_end;
         sec_ff <= div_end & hsel_ff;
         hsel_ff <= hsel_ff ^ div_end;
      end
   end

   // AXI4-Lite slave.
   utic_pkg::utic_axi_rsp_t rsp_ff;
   logic aw_ok_ff;
   logic w_ok_ff;
   logic [`UTIC_AW-1:0] awa_ff;
   logic [31:0] wd_ff;
   logic [3:0] ws_ff;
   wire aw_take = axi_req.awvalid & rsp_ff.awready;
   wire w_take = axi_req.wvalid & rsp_ff.wready;
   wire ar_take = axi_req.arvalid & rsp_ff.arready;
   wire wr_fire = aw_ok_ff & w_ok_ff & ~rsp_ff.bvalid;
   wire nxt_aw_ok = aw_take | (aw_ok_ff & ~wr_fire);
   wire nxt_w_ok = w_take | (w_ok_ff & ~wr_fire);
   wire nxt_rvalid = ar_take | (rsp_ff.rvalid & ~axi_req.rready);
   wire hit_cmd = (awa_ff == `UTIC_CMD_OFS);
   wire hit_cfg = (awa_ff == `UTIC_CFG_OFS);
   wire hit_ont = (awa_ff == `UTIC_ONT_OFS);
   wire hit_offt = (awa_ff == `UTIC_OFFT_OFS);
   wire wr_hit = hit_cmd | hit_cfg | hit_ont | hit_offt;
   wire [31:0] wmask = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};
   wire [`UTIC_AW-1:0] ra = axi_req.araddr;
   logic [2:0] cfg_ff;
   logic [`UTIC_TMR_W-1:0] ont_min_ff;
   logic [`UTIC_TMR_W-1:0] offt_min_ff;
   utic_pkg::utic_stat_t stat;
   wire rd_hit = (ra == `UTIC_CMD_OFS) | (ra == `UTIC_CFG_OFS) | (ra == `UTIC_ONT_OFS)
      | (ra == `UTIC_OFFT_OFS) | (ra == `UTIC_STAT_OFS);
   wire [31:0] rd_word = (ra == `UTIC_CFG_OFS) ? {29'h0, cfg_ff} :
      (ra == `UTIC_ONT_OFS) ? {21'h0, ont_min_ff} :
      (ra == `UTIC_OFFT_OFS) ? {21'h0, offt_min_ff} :
      (ra == `UTIC_STAT_OFS) ? {15'h0, stat} : 32'h0;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rsp_ff <= '0;
         aw_ok_ff <= 1'h0;
         w_ok_ff <= 1'h0;
         awa_ff <= '0;
         wd_ff <= 32'h0;
         ws_ff <= 4'h0;
      end else begin
         aw_ok_ff <= nxt_aw_ok;
         w_ok_ff <= nxt_w_ok;
         if (aw_take) begin
            awa_ff <= axi_req.awaddr;
         end
         if (w_take) begin
            wd_ff <= axi_req.wdata;
            ws_ff <= axi_req.wstrb;
         end
         rsp_ff.awready <= ~nxt_aw_ok;
         rsp_ff.wready <= ~nxt_w_ok;
         rsp_ff.arready <= ~nxt_rvalid;
         rsp_ff.rvalid <= nxt_rvalid;
         if (wr_fire) begin
            rsp_ff.bvalid <= 1'h1;
            rsp_ff.bresp <= wr_hit ? `UTIC_RESP_OKAY : `UTIC_RESP_SLVERR;
         end else if (axi_req.bready) begin
            rsp_ff.bvalid <= 1'h0;
         end
         if (ar_take) begin
            rsp_ff.rdata <= rd_word;
            rsp_ff.rresp <= rd_hit ? `UTIC_RESP_OKAY : `UTIC_RESP_SLVERR;
         end
      end
   end
   assign axi_rsp = rsp_ff;

   // Remote commands and register writes.
   wire [3:0] cmd = (wr_fire & hit_cmd & ws_ff[0]) ? wd_ff[3:0] : 4'h0;
   wire c_onoff = cmd[`UTIC_CMD_ONOFF];
   wire c_ion = cmd[`UTIC_CMD_ION];
   wire c_tdec5 = cmd[`UTIC_CMD_TDEC5];
   wire any_btn = |cmd;
   wire ont_wr = wr_fire & hit_ont;
   wire offt_wr = wr_fire & hit_offt;
   wire [31:0] ont_w = ({21'h0, ont_min_ff} & ~wmask) | (wd_ff & wmask);
   wire [31:0] offt_w = ({21'h0, offt_min_ff} & ~wmask) | (wd_ff & wmask);
   wire [31:0] cfg_w = ({29'h0, cfg_ff} & ~wmask) | (wd_ff & wmask);

   // Front switch hold time, judged at release.
   logic sw_q_ff;
   logic [4:0] sw_sec_ff;
   wire sw_rel = sw_q_ff & ~auto_sw;
   wire win1 = sw_rel & (sw_sec_ff < 5'(`UTIC_W1_S));
   wire win2 = sw_rel & ~win1 & (sw_sec_ff < 5'(`UTIC_W2_S));
   wire win3 = sw_rel & (sw_sec_ff >= 5'(`UTIC_W2_S)) & (sw_sec_ff < 5'(`UTIC_W3_S));
   wire win4 = sw_rel & (sw_sec_ff >= 5'(`UTIC_W3_S)) & (sw_sec_ff < 5'(`UTIC_W4_S));
   wire win5 = sw_rel & (sw_sec_ff >= 5'(`UTIC_W4_S)) & (sw_sec_ff < 5'(`UTIC_W5_S));
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sw_q_ff <= 1'h0;
         sw_sec_ff <= 5'h0;
      end else begin
         sw_q_ff <= auto_sw;
         if (~auto_sw) begin
            sw_sec_ff <= 5'h0;
         end else if (sec_ff & (sw_sec_ff != 5'h1F)) begin
            sw_sec_ff <= sw_sec_ff + 5'h1;
         end
      end
   end

   // Delay timers and the delay-on sampling run.
   utic_pkg::utic_unit_t unit_ff;
   utic_pkg::utic_unit_t nxt_unit;
   utic_pkg::utic_mode_t mode_ff;
   utic_pkg::utic_mode_t nxt_mode;
   logic ont_act_ff;
   logic offt_act_ff;
   logic [16:0] ont_rem_ff;
   logic [16:0] offt_rem_ff;
   logic [4:0] samp_ff;
   wire ont_fire = ont_act_ff & sec_ff & (ont_rem_ff == 17'h1);
   wire offt_fire = offt_act_ff & sec_ff & (offt_rem_ff == 17'h1);
   wire samp_go = ont_act_ff & sec_ff & (ont_rem_ff == LEAD_S);
   wire samp_on = (samp_ff != 5'h0) & (unit_ff == utic_pkg::UNIT_OFF);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg_ff <= `UTIC_CFG_RST;
         ont_min_ff <= '0;
         offt_min_ff <= '0;
         ont_act_ff <= 1'h0;
         offt_act_ff <= 1'h0;
         ont_rem_ff <= 17'h0;
         offt_rem_ff <= 17'h0;
         samp_ff <= 5'h0;
      end else begin
         if (wr_fire & hit_cfg) begin
            cfg_ff <= cfg_w[2:0];
         end
         if (ont_wr) begin
            ont_min_ff <= ont_w[`UTIC_TMR_W-1:0];
            ont_rem_ff <= 17'(ont_w[`UTIC_TMR_W-1:0]) * 17'(`UTIC_SEC_PER_MIN);
            ont_act_ff <= (ont_w[`UTIC_TMR_W-1:0] != '0);
         end else if (ont_fire) begin
            ont_act_ff <= 1'h0;
         end else if (ont_act_ff & sec_ff) begin
            ont_rem_ff <= ont_rem_ff - 17'h1;
         end
         if (offt_wr) begin
            offt_min_ff <= offt_w[`UTIC_TMR_W-1:0];
            offt_rem_ff <= 17'(offt_w[`UTIC_TMR_W-1:0]) * 17'(`UTIC_SEC_PER_MIN);
            offt_act_ff <= (offt_w[`UTIC_TMR_W-1:0] != '0);
         end else if (offt_fire) begin
            offt_act_ff <= 1'h0;
         end else if (offt_act_ff & sec_ff) begin
            offt_rem_ff <= offt_rem_ff - 17'h1;
         end
         if (samp_go) begin
            samp_ff <= 5'(`UTIC_SAMPLE_S);
         end else if (sec_ff & (samp_ff != 5'h0)) begin
            samp_ff <= samp_ff - 5'h1;
         end
      end
   end

   // Unit state.
   logic init_ff;
   logic brk_ff;
   logic lock_ff;
   logic ion_req_ff;
   logic code_arm_ff;
   wire restart = init_ff & was_running & ~timer_was_set;
   wire cfg_run = c_onoff | ont_fire;
   always_comb begin
      nxt_unit = unit_ff;
      nxt_mode = mode_ff;
      unique case (unit_ff)
         utic_pkg::UNIT_OFF: begin
            if (cfg_run & ~brk_ff) begin
               nxt_unit = utic_pkg::UNIT_RUN;
               nxt_mode = utic_pkg::utic_mode_t'(cfg_ff[`UTIC_CFG_MODE_LSB +: 2]);
            end else if (c_ion & ~brk_ff) begin
               nxt_unit = utic_pkg::UNIT_ION;
            end
         end
         utic_pkg::UNIT_RUN: begin
            if (c_onoff | offt_fire | brk_ff) begin
               nxt_unit = utic_pkg::UNIT_OFF;
            end
         end
         utic_pkg::UNIT_ION: begin
            if (c_onoff | c_ion | offt_fire) begin
               nxt_unit = utic_pkg::UNIT_OFF;
            end
         end
         utic_pkg::UNIT_HSTBY: begin
            if (c_onoff) begin
               nxt_unit = utic_pkg::UNIT_OFF;
            end else if (c_tdec5 & ~brk_ff) begin
               nxt_unit = utic_pkg::UNIT_RUN;
               nxt_mode = utic_pkg::MODE_HEAT;
            end
         end
      endcase
      if (win1 & (unit_ff == utic_pkg::UNIT_RUN)) begin
         nxt_unit = utic_pkg::UNIT_OFF;
      end else if (win1 & ~brk_ff) begin
         nxt_unit = utic_pkg::UNIT_RUN;
         nxt_mode = utic_pkg::MODE_AUTO;
      end else if (win2 & ~brk_ff) begin
         nxt_unit = utic_pkg::UNIT_RUN;
         nxt_mode = utic_pkg::MODE_COOL;
      end else if (win3) begin
         nxt_unit = utic_pkg::UNIT_HSTBY;
      end
      if (restart) begin
         nxt_unit = utic_pkg::UNIT_RUN;
         nxt_mode = utic_pkg::utic_mode_t'(cfg_ff[`UTIC_CFG_MODE_LSB +: 2]);
      end
   end

   // Ionizer request, lockout and error cycling.
   logic err_act_ff;
   logic err_rest_ff;
   logic [10:0] err_tmr_ff;
   logic [4:0] err_cnt_ff;
   wire enter_run = (nxt_unit == utic_pkg::UNIT_RUN) & (unit_ff != utic_pkg::UNIT_RUN);
   wire idle_nxt = (nxt_unit == utic_pkg::UNIT_OFF) | (nxt_unit == utic_pkg::UNIT_HSTBY);
   wire nxt_ion_req = (idle_nxt | enter_run) ? 1'h0 :
      (nxt_unit == utic_pkg::UNIT_ION) ? 1'h1 :
      c_ion ? ~ion_req_ff : ion_req_ff;
   wire lock_clr = (c_onoff & (unit_ff != utic_pkg::UNIT_OFF))
      | (win1 & (unit_ff == utic_pkg::UNIT_RUN));
   wire want_ion = ion_req_ff & ~lock_ff & ~brk_ff;
   wire ion_drv = want_ion & ~(err_act_ff & err_rest_ff);
   wire err_start = want_ion & ~err_act_ff & plant.ionizer & ~ion_fb;
   wire err_clr = ~want_ion | (err_act_ff & ~err_rest_ff & plant.ionizer & ion_fb);
   wire err_step = err_act_ff & sec_ff & (err_tmr_ff == 11'h1);
   wire err_done = err_step & ~err_rest_ff & (err_cnt_ff == 5'(`UTIC_ION_CYCLES - 1));
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         err_act_ff <= 1'h0;
         err_rest_ff <= 1'h0;
         err_tmr_ff <= 11'h0;
         err_cnt_ff <= 5'h0;
      end else if (err_clr) begin
         err_act_ff <= 1'h0;
         err_rest_ff <= 1'h0;
         err_tmr_ff <= 11'h0;
         err_cnt_ff <= 5'h0;
      end else if (err_start) begin
         err_act_ff <= 1'h1;
         err_rest_ff <= 1'h0;
         err_tmr_ff <= ON_S;
      end else if (err_step) begin
         err_rest_ff <= ~err_rest_ff;
         err_tmr_ff <= err_rest_ff ? ON_S : REST_S;
         err_cnt_ff <= err_cnt_ff + {4'h0, ~err_rest_ff};
      end else if (err_act_ff & sec_ff) begin
         err_tmr_ff <= err_tmr_ff - 11'h1;
      end
   end

   // Breakdown detection and restart delay.
   logic [1:0] brk_cnt_ff;
   logic rs_pick_ff;
   logic [7:0] rs_ff;
   logic [7:0] lfsr_ff;
   logic [4:0] odf_ff;
   wire brk_cond = ~plant.ionizer & ion_fb;
   wire [7:0] rs_pat = lfsr_ff % 8'(`UTIC_RS_PATTERNS);
   wire [7:0] rs_dly = 8'(`UTIC_RS_MIN_S) + 8'(rs_pat * 8'(`UTIC_RS_STEP_S));
   wire lfsr_in = lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3] ^ ion_fb ^ auto_sw;
   wire comp = (unit_ff == utic_pkg::UNIT_RUN) & (rs_ff == 8'h0) & ~rs_pick_ff & ~brk_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         brk_cnt_ff <= 2'h0;
         brk_ff <= 1'h0;
         rs_pick_ff <= 1'h0;
         rs_ff <= 8'h0;
         lfsr_ff <= `UTIC_LFSR_RST;
         odf_ff <= 5'h0;
      end else begin
         lfsr_ff <= {lfsr_ff[6:0], lfsr_in};
         if (~brk_cond) begin
            brk_cnt_ff <= 2'h0;
            brk_ff <= 1'h0;
         end else if (sec_ff & ~brk_ff) begin
            if (brk_cnt_ff == 2'(`UTIC_BRK_S)) begin
               brk_ff <= 1'h1;
            end else begin
               brk_cnt_ff <= brk_cnt_ff + 2'h1;
            end
         end
         if (restart) begin
            rs_pick_ff <= 1'h1;
         end else if (rs_pick_ff & half_ff) begin
            rs_pick_ff <= 1'h0;
            rs_ff <= rs_dly;
         end else if (nxt_unit != utic_pkg::UNIT_RUN) begin
            rs_pick_ff <= 1'h0;
            rs_ff <= 8'h0;
         end else if (sec_ff & (rs_ff != 8'h0)) begin
            rs_ff <= rs_ff - 8'h1;
         end
         if (comp) begin
            odf_ff <= 5'(`UTIC_ODFAN_HOLD_S);
         end else if (sec_ff & (odf_ff != 5'h0)) begin
            odf_ff <= odf_ff - 5'h1;
         end
      end
   end

   // Settings toggled from the switch, and the buzzer.
   logic beep_en_ff;
   logic sens_en_ff;
   logic [1:0] code_ff;
   logic [2:0] beep_left_ff;
   logic beep_ph_ff;
   wire beep4 = brk_ff & any_btn;
   wire beep1 = (lock_ff & c_ion) | (beep_en_ff & any_btn);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         init_ff <= 1'h1;
         unit_ff <= utic_pkg::UNIT_OFF;
         mode_ff <= utic_pkg::MODE_AUTO;
         ion_req_ff <= 1'h0;
         lock_ff <= 1'h0;
         code_arm_ff <= 1'h0;
         code_ff <= 2'h0;
         beep_en_ff <= `UTIC_BEEP_EN_RST;
         sens_en_ff <= `UTIC_SENS_EN_RST;
      end else begin
         init_ff <= 1'h0;
         unit_ff <= nxt_unit;
         mode_ff <= nxt_mode;
         ion_req_ff <= nxt_ion_req;
         lock_ff <= err_done | (lock_ff & ~lock_clr);
         if (win4) begin
            code_arm_ff <= 1'h1;
         end else if (sw_rel | (code_arm_ff & c_tdec5)) begin
            code_arm_ff <= 1'h0;
         end
         if (code_arm_ff & c_tdec5) begin
            code_ff <= code_ff + 2'h1;
         end
         if (win5 & cfg_ff[`UTIC_CFG_TGL]) begin
            sens_en_ff <= ~sens_en_ff;
         end
         if (win5 & ~cfg_ff[`UTIC_CFG_TGL]) begin
            beep_en_ff <= ~beep_en_ff;
         end
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         beep_left_ff <= 3'h0;
         beep_ph_ff <= 1'h0;
      end else if (beep4) begin
         beep_left_ff <= 3'(`UTIC_BRK_BEEPS);
         beep_ph_ff <= 1'h0;
      end else if (beep1) begin
         beep_left_ff <= 3'h1;
         beep_ph_ff <= 1'h0;
      end else if (half_ff & (beep_left_ff != 3'h0)) begin
         beep_ph_ff <= ~beep_ph_ff;
         beep_left_ff <= beep_left_ff - {2'h0, beep_ph_ff};
      end
   end

   // Status word and registered plant outputs.
   wire run = (unit_ff == utic_pkg::UNIT_RUN);
   wire ion_only = (unit_ff == utic_pkg::UNIT_ION);
   wire pwr_blk = hot_start | deicing | mode_judge;
   assign stat = {samp_on, mode_ff, code_ff, comp, offt_act_ff, ont_act_ff, sens_en_ff,
      beep_en_ff, code_arm_ff, unit_ff == utic_pkg::UNIT_HSTBY, brk_ff, lock_ff,
      plant.ionizer, ion_only, run};
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         plant <= '0;
      end else begin
         plant.indoor_fan <= run | ion_only | samp_on;
         plant.lowest_fan_step <= samp_on;
         plant.outdoor_fan <= comp | (odf_ff != 5'h0) | samp_on;
         plant.comp <= comp;
         plant.ionizer <= ion_drv;
         plant.vane_cool_law <= ion_only;
         plant.led_power <= samp_on ? hsel_ff : (run & (~pwr_blk | hsel_ff));
         plant.led_timer <= (abnormal | brk_ff) ? hsel_ff : (ont_act_ff | offt_act_ff);
         plant.led_ion <= ion_req_ff & (~(lock_ff | brk_ff) | hsel_ff);
         plant.buzzer <= beep_ph_ff & (beep_left_ff != 3'h0);
         plant.ionizer_breakdown_code <= brk_ff;
         plant.sensor_detect_en <= sens_en_ff;
         plant.mode <= mode_ff;
         plant.code_sel <= code_ff;
      end
   end
endmodule
`default_nettype wire

// [dv/utic_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module utic_ctrl_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire utic_pkg::utic_axi_req_t axi_req,
   input wire utic_pkg::utic_axi_rsp_t axi_rsp,
   input wire logic ion_fb,
   input wire utic_pkg::utic_plant_t plant
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
   wr_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
   brk_stop_a: assert property ($rose(plant.ionizer_breakdown_code) |-> ##[0:2] !plant.comp)
      else $error("unit kept running in breakdown");
   brk_cause_a: assert property ($rose(plant.ionizer_breakdown_code) |->
      ion_fb && $past(ion_fb, 40)) else $error("breakdown raised too early");
   brk_blink_a: assert property ($rose(plant.ionizer_breakdown_code) |->
      ##[1:24] $changed(plant.led_timer)) else $error("timer lamp not blinking");
   brk_clear_a: assert property (!ion_fb [*3] |=> !plant.ionizer_breakdown_code)
      else $error("breakdown not cleared");
   ion_fan_a: assert property (plant.ionizer |-> plant.indoor_fan)
      else $error("ionizer without fan");
   odfan_hold_a: assert property ($fell(plant.comp) |-> plant.outdoor_fan [*8])
      else $error("outdoor fan stopped early");
   cover property ($rose(plant.comp));
   cover property ($rose(plant.ionizer_breakdown_code));
   cover property (plant.ionizer && !plant.led_power);
endmodule
bind utic_ctrl utic_ctrl_monitor u_utic_ctrl_monitor(.mclk(mclk), .rst(rst), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .ion_fb(ion_fb), .plant(plant));
`default_nettype wire

// [dv/utic_far.sv]
`timescale 1ns/1ps
`default_nettype none
module utic_far #(
   parameter int S = 20
) (
   input wire logic mclk,
   input wire logic ionizer,
   input wire logic stuck,
   input wire logic dead,
   input wire logic [4:0] hold_s,
   input wire logic go,
   output logic auto_sw,
   output logic ion_fb
);
   int n = 0;
   initial begin
      auto_sw = 1'h0;
      ion_fb = 1'h0;
   end
   // Switch is held for the commanded whole seconds.
   always @(posedge mclk) begin
      if (go) n <= hold_s * S;
      else if (n > 0) n <= n - 1;
      auto_sw <= n > 0;
   end
   // Feedback follows the ionizer, stays low when dead, or stays high when stuck.
   always @(posedge mclk) ion_fb <= stuck | (ionizer & ~dead);
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int S = 20;
   logic mclk = 1'h0, rst = 1'h1, was_running = 1'h1, stuck = 1'h0, go = 1'h0;
   logic hot_start = 1'h0, deicing = 1'h0, mode_judge = 1'h0, abnormal = 1'h0;
   logic timer_was_set = 1'h0, auto_sw, ion_fb, dead = 1'h0;
   logic [4:0] hold = 5'h00;
   logic [31:0] d;
   logic [1:0] r;
   logic [15:0] x = 16'h5DFF;
   int failures = 0, cmp_count = 0, k = 0;
   utic_pkg::utic_axi_req_t q = '0;
   utic_pkg::utic_axi_rsp_t rsp;
   utic_pkg::utic_plant_t plant;
   always #5 mclk = ~mclk;
   utic_ctrl #(.HALF_CYCLES(10)) u_utic_ctrl(.mclk(mclk), .rst(rst), .axi_req(q),
      .axi_rsp(rsp), .auto_sw(auto_sw), .ion_fb(ion_fb), .was_running(was_running),
      .timer_was_set(timer_was_set), .hot_start(hot_start), .deicing(deicing),
      .mode_judge(mode_judge), .abnormal(abnormal), .plant(plant));
   utic_far #(.S(S)) u_utic_far(.mclk(mclk), .ionizer(plant.ionizer), .stuck(stuck),
      .dead(dead), .hold_s(hold), .go(go), .auto_sw(auto_sw), .ion_fb(ion_fb));
   function logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task secs(input int n);
      repeat (n * S) @(posedge mclk);
   endtask
   function logic pick(input int f);
      return f == 0 ? plant.buzzer : f == 1 ? plant.led_timer : plant.led_power;
   endfunction
   // Counts rising edges of the picked output over c clocks into k.
   task rises(input int f, input int c);
      logic p;
      p = pick(f);
      k = 0;
      repeat (c) begin
         @(posedge mclk);
         if (pick(f) && !p) k++;
         p = pick(f);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw;
      ta = 1'h0;
      tw = 1'h0;
      @(posedge mclk);
      q.awvalid <= 1'h1;
      q.awaddr <= a;
      q.wvalid <= 1'h1;
      q.wdata <= v;
      q.wstrb <= 4'hF;
      q.bready <= 1'h1;
      while (!(ta && tw)) begin
         @(posedge mclk);
         if (!ta && rsp.awready) begin
            ta = 1'h1;
            q.awvalid <= 1'h0;
         end
         if (!tw && rsp.wready) begin
            tw = 1'h1;
            q.wvalid <= 1'h0;
         end
      end
      do @(posedge mclk); while (!rsp.bvalid);
      q.bready <= 1'h0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge mclk);
      q.arvalid <= 1'h1;
      q.araddr <= a;
      q.rready <= 1'h1;
      do @(posedge mclk); while (!rsp.arready);
      q.arvalid <= 1'h0;
      do @(posedge mclk); while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
      q.rready <= 1'h0;
   endtask
   task press(input logic [4:0] s);
      go <= 1'h1;
      hold <= s;
      @(posedge mclk);
      go <= 1'h0;
      secs(s + 2);
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      results;
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      rd(8'h10);
      chk("run", 32'h1, d[0]);
      secs(170);
      chk("comp early", 32'h0, plant.comp);
      for (int i = 0; i < 70 * S && !plant.comp; i++) @(posedge mclk);
      chk("comp", 32'h1, plant.comp);
      $display("restart test done");
      wr(8'h00, 32'h2);
      secs(1);
      chk("ion run", 32'h7, {plant.ionizer, plant.led_ion, plant.led_power});
      wr(8'h00, 32'h1);
      secs(1);
      chk("ion stop", 32'h1, {plant.ionizer, plant.outdoor_fan});
      secs(31);
      chk("od fan", 32'h0, plant.outdoor_fan);
      wr(8'h00, 32'h1);
      secs(1);
      chk("ion memory", 32'h0, plant.ionizer);
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h2);
      secs(1);
      chk("ion only", 32'hB, {plant.ionizer, plant.led_power, plant.vane_cool_law,
         plant.indoor_fan});
      wr(8'h0C, 32'h1);
      secs(62);
      chk("off timer", 32'h0, plant.ionizer);
      $display("ionizer test done");
      press(6);
      rd(8'h10);
      chk("cool", 32'h3, {d[15:14], d[0]});
      press(2);
      press(2);
      rd(8'h10);
      chk("auto", 32'h1, {d[15:14], d[0]});
      press(2);
      press(9);
      rd(8'h10);
      chk("heat standby", 32'h1, d[5]);
      wr(8'h00, 32'h4);
      secs(1);
      rd(8'h10);
      chk("heat", 32'h7, {d[15:14], d[0]});
      chk("heat mode", 32'h3, plant.mode);
      hot_start <= 1'h1;
      secs(1);
      rises(2, 2 * S);
      chk("power blink", 32'h2, k);
      hot_start <= 1'h0;
      dead <= 1'h1;
      wr(8'h00, 32'h2);
      secs(12);
      chk("ion rest", 32'h1, {plant.ionizer, plant.led_ion});
      dead <= 1'h0;
      wr(8'h00, 32'h2);
      press(12);
      wr(8'h00, 32'h4);
      secs(1);
      chk("code", 32'h1, plant.code_sel);
      wr(8'h04, 32'h4);
      press(17);
      chk("sensor detect", 32'h0, plant.sensor_detect_en);
      $display("switch test done");
      stuck <= 1'h1;
      secs(4);
      chk("brk code", 32'h1, plant.ionizer_breakdown_code);
      rd(8'h10);
      chk("brk stop", 32'h0, d[0]);
      wr(8'h00, 32'h8);
      rises(0, 5 * S);
      chk("beeps", 32'h4, k);
      stuck <= 1'h0;
      secs(1);
      chk("brk clear", 32'h0, plant.ionizer_breakdown_code);
      abnormal <= 1'h1;
      secs(1);
      rises(1, 2 * S);
      chk("fault blink", 32'h2, k);
      abnormal <= 1'h0;
      wr(8'h08, 32'h3D);
      secs(62);
      chk("sampling", 32'hF, {plant.lowest_fan_step, plant.indoor_fan, plant.outdoor_fan,
         plant.led_timer});
      rises(2, 2 * S);
      chk("sample blink", 32'h2, k);
      wr(8'h08, 32'h0);
      rd(8'h14);
      chk("unmapped", 32'h2, r);
      for (int i = 0; i < 3; i++) begin
         x = nx(x);
         wr(8'h04, {16'h0000, x});
         rd(8'h04);
         chk("cfg", {29'h0, x[2:0]}, d);
      end
      $display("register test done");
      results;
   end
endmodule
`default_nettype wire
